// File: hw/mqf_defines.vh
`ifndef MQF_DEFINES_VH
`define MQF_DEFINES_VH
// Summary of operation
// - each queue keeps almost-empty status; active flag shows the read-selected queue only
// - every queue has its own almost-empty offset, zero up to its depth at the time the offset is written
// - default offset is 8 with strap low at reset, 128 with strap high
// - offsets, depths and widths are loadable by software instead of defaults
// - read queue select takes effect; its status shows on the second edge after
// - active almost-empty flag is double registered; read boundary drops it two clocks later
// - a write lifting the queue raises the active flag two clocks later
// - active almost-empty flag changes only on a rising clock edge or when reset is asserted
// - writes to unselected queues still update their internal almost-empty status
// - every queue's almost-empty status is copied onto a four-bit bus
// - output-valid goes low after first write, second for narrow-in wide-out
// - output-valid falls after skew plus one clock; last-word read raises it at once
// - full after depth plus one or depth writes by selection; depth for wide-in narrow-out
// - narrow-in wide-out: full after twice depth plus two, or twice depth writes
// - a write drops full at once; a read releases it at once, on the edge of the read
// - active flag rises after offset plus two, offset plus one, or twice offset plus two or four
// - bus bit rises after offset plus one writes, plus two with fall-through, twice that for narrow-in wide-out
// - bus bit falls two clocks after a read, rises two clocks after a write
// - output-valid rises on the edge of the enabled read that takes the last word

// ********************************
// register map (byte addresses)
// ********************************
`define MQF_ADDR_CTRL       8'h00
`define MQF_ADDR_STATUS     8'h04
`define MQF_ADDR_OFS_BASE   8'h10
`define MQF_ADDR_DEPTH_BASE 8'h20
`define MQF_ADDR_COUNT_BASE 8'h30

// ********************************
// field positions and reset values
// ********************************
`define MQF_CTRL_IN18       0
`define MQF_CTRL_OUT18      1
`define MQF_CTRL_RESET      2'h0
`define MQF_STAT_AE_LSB     0
`define MQF_STAT_FULL_LSB   4
`define MQF_STAT_OV_LSB     8
`define MQF_STAT_RDQ_LSB    12
`define MQF_STAT_WRQ_LSB    14
`define MQF_OFS_DEF_LO      16'h0008
`define MQF_OFS_DEF_HI      16'h0080
`define MQF_DEPTH_DEF       16'h2000

// ********************************
// timing
// ********************************
`define MQF_INIT_WAIT       2'h3

`endif

// File: hw/mqf_queue_flags.v
`timescale 1ns/1ps
`include "mqf_defines.vh"

module mqf_queue_flags #(
	parameter CNT_W = 18,
	parameter OFS_W = 16
) (
	input  wire             ref_clk,     // system clock
	input  wire             rst,         // async reset, active high
	input  wire             wr_evt,      // write aimed at this queue
	input  wire             rd_evt,      // enabled read aimed at this queue
	input  wire             rd_here,     // queue is selected on the read port
	input  wire             in18,        // write port is 18 bits wide
	input  wire             out18,       // read port is 18 bits wide
	input  wire             ofs_load,    // load almost-empty offset
	input  wire [OFS_W-1:0] ofs_value,   // offset to load
	input  wire             dep_load,    // load queue depth
	input  wire [OFS_W-1:0] dep_value,   // depth to load
	output reg  [OFS_W-1:0] ofs_reg,     // almost-empty offset
	output reg  [OFS_W-1:0] dep_reg,     // queue depth in words of the wider port
	output reg  [CNT_W-1:0] cnt_reg,     // fill level in 9-bit units
	output reg              ae_n_reg,    // almost-empty, first stage
	output wire             valid_now,   // a whole read word is present
	output wire             full_now     // queue is full after this edge
);

	// ********************************
	// threshold arithmetic
	// ********************************
	function [CNT_W-1:0] scaled;
		input             dbl;
		input [OFS_W-1:0] base;
		input             plus;
		reg   [CNT_W-1:0] sum;
		begin
			sum = {{(CNT_W-OFS_W){1'b0}}, base} + {{(CNT_W-1){1'b0}}, plus};
			scaled = dbl ? {sum[CNT_W-2:0], 1'b0} : sum;
		end
	endfunction

	wire [CNT_W-1:0] wu = {{(CNT_W-2){1'b0}}, in18, !in18};
	wire [CNT_W-1:0] ru = {{(CNT_W-2){1'b0}}, out18, !out18};
	wire             dbl = in18 | out18;
	wire [CNT_W-1:0] unit_k = {{(CNT_W-2){1'b0}}, dbl, !dbl};
	reg              ft_reg;
	wire             ft_next;
	wire [CNT_W-1:0] full_lim = scaled(dbl, dep_reg, ft_reg);
	wire             wr_ok = wr_evt && (cnt_reg < full_lim);
	wire             rd_ok = rd_evt && (cnt_reg >= ru);
	wire [CNT_W-1:0] cnt_next = cnt_reg + (wr_ok ? wu : {CNT_W{1'b0}})
		- (rd_ok ? ru : {CNT_W{1'b0}});
	// fall-through word adds one unit of the wider port to the boundary
	wire [CNT_W-1:0] ae_lim = scaled(dbl, ofs_reg, 1'b1) + (ft_reg ? unit_k : {CNT_W{1'b0}});

	// first word counts toward fall-through only with both ports on this queue
	assign ft_next = (wr_ok && cnt_reg == 0) ? (rd_here && !(in18 && !out18)) : ft_reg;
	assign valid_now = (cnt_reg >= ru) && (cnt_next >= ru);
	assign full_now = cnt_next >= scaled(dbl, dep_reg, ft_next);

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_reg  <= {CNT_W{1'b0}};
			ft_reg   <= 1'b0;
			ae_n_reg <= 1'b0;
			ofs_reg  <= `MQF_OFS_DEF_LO;
			dep_reg  <= `MQF_DEPTH_DEF;
		end else begin
			cnt_reg  <= cnt_next;
			ft_reg   <= ft_next;
			ae_n_reg <= cnt_reg >= ae_lim;
			if (ofs_load) begin
				ofs_reg <= (ofs_value > dep_reg) ? dep_reg : ofs_value;
			end
			if (dep_load) begin
				dep_reg <= dep_value;
			end
		end
	end

endmodule // mqf_queue_flags

// File: hw/mqf_multiqueue_flags.v
`timescale 1ns/1ps
`include "mqf_defines.vh"

module mqf_multiqueue_flags #(
	parameter NQ    = 4,
	parameter QW    = 2,
	parameter OFS_W = 16,
	parameter CNT_W = 18
) (
	input  wire          ref_clk,                       // 50 MHz clock
	input  wire          rst,                           // async reset, active high
	input  wire          default_offset_select,         // strap: default offset choice
	input  wire          write_en,                      // write a word this edge
	input  wire [QW-1:0] write_queue_select,            // write queue number
	input  wire          write_select_strobe,           // take new write queue
	input  wire          read_en,                       // read a word this edge
	input  wire [QW-1:0] read_queue_select_bus,         // read queue number
	input  wire          read_select_strobe,            // take new read queue
	input  wire [7:0]    avs_address,                   // byte address
	input  wire          avs_read,                      // register read
	input  wire          avs_write,                     // register write
	input  wire [31:0]   avs_writedata,                 // write data
	input  wire [3:0]    avs_byteenable,                // byte lanes
	output reg  [31:0]   avs_readdata,                  // read data
	output reg           avs_waitrequest,               // stall the master
	output reg           active_almost_empty_flag_n,    // selected queue almost empty
	output reg  [NQ-1:0] per_queue_almost_empty_bus_n,  // all queues almost empty
	output reg           output_valid_flag_n,           // output word valid, low true
	output reg           queue_full_flag_n              // write queue full, low true
);

	// ********************************
	// helpers
	// ********************************
	function [OFS_W-1:0] lane_merge;
		input [OFS_W-1:0] old;
		input [31:0]      wdata;
		input [3:0]       be;
		begin
			lane_merge = old;
			if (be[0]) begin
				lane_merge[7:0] = wdata[7:0];
			end
			if (be[1]) begin
				lane_merge[15:8] = wdata[15:8];
			end
		end
	endfunction

	function [QW-1:0] idx_of;
		input [7:0] addr;
		begin
			idx_of = addr[QW+1:2];
		end
	endfunction

	// ********************************
	// strap capture
	// ********************************
	// the strap is asynchronous to the clock, so it is synchronised first;
	// defaults load once the synchroniser has settled after reset release
	reg       df_meta_reg;
	reg       df_sync_reg;
	reg [1:0] init_cnt_reg;
	reg       init_busy_reg;
	wire      init_load = init_busy_reg && (init_cnt_reg == `MQF_INIT_WAIT);

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			df_meta_reg   <= 1'b0;
			df_sync_reg   <= 1'b0;
			init_cnt_reg  <= 2'h0;
			init_busy_reg <= 1'b1;
		end else begin
			df_meta_reg <= default_offset_select;
			df_sync_reg <= df_meta_reg;
			if (init_busy_reg) begin
				init_cnt_reg <= init_cnt_reg + 2'h1;
				if (init_load) begin
					init_busy_reg <= 1'b0;
				end
			end
		end
	end

	wire [OFS_W-1:0] ofs_default = df_sync_reg ? `MQF_OFS_DEF_HI : `MQF_OFS_DEF_LO;

	// ********************************
	// port queue selection
	// ********************************
	reg          rd_pend_reg;
	reg [QW-1:0] rd_pend_q_reg;
	reg [QW-1:0] rd_q_reg;
	reg          wr_pend_reg;
	reg [QW-1:0] wr_pend_q_reg;
	reg [QW-1:0] wr_q_reg;

	// a select becomes the active queue one edge later; valid and full follow then, the active flag on the second
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_pend_reg   <= 1'b0;
			rd_pend_q_reg <= {QW{1'b0}};
			rd_q_reg      <= {QW{1'b0}};
			wr_pend_reg   <= 1'b0;
			wr_pend_q_reg <= {QW{1'b0}};
			wr_q_reg      <= {QW{1'b0}};
		end else begin
			rd_pend_reg <= read_select_strobe;
			if (read_select_strobe) begin
				rd_pend_q_reg <= read_queue_select_bus;
			end
			if (rd_pend_reg) begin
				rd_q_reg <= rd_pend_q_reg;
			end
			wr_pend_reg <= write_select_strobe;
			if (write_select_strobe) begin
				wr_pend_q_reg <= write_queue_select;
			end
			if (wr_pend_reg) begin
				wr_q_reg <= wr_pend_q_reg;
			end
		end
	end

	wire [QW-1:0] rd_q_next = rd_pend_reg ? rd_pend_q_reg : rd_q_reg;
	wire [QW-1:0] wr_q_next = wr_pend_reg ? wr_pend_q_reg : wr_q_reg;

	// ********************************
	// configuration and bus decode
	// ********************************
	reg  [1:0]    ctrl_reg;
	wire          in18 = ctrl_reg[`MQF_CTRL_IN18];
	wire          out18 = ctrl_reg[`MQF_CTRL_OUT18];
	wire          bus_wr = avs_write && !avs_waitrequest;
	wire [7:0]    a_base = {avs_address[7:4], 4'h0};
	wire          a_low_ok = (avs_address[1:0] == 2'h0) && (avs_address[3:2] < NQ);
	wire [NQ-1:0] ofs_load;
	wire [NQ-1:0] dep_load;
	wire [NQ-1:0] ae_stage;
	wire [NQ-1:0] valid_now;
	wire [NQ-1:0] full_now;
	wire [OFS_W*NQ-1:0] ofs_all;
	wire [OFS_W*NQ-1:0] dep_all;
	wire [CNT_W*NQ-1:0] cnt_all;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `MQF_CTRL_RESET;
		end else if (bus_wr && avs_address == `MQF_ADDR_CTRL && avs_byteenable[0]) begin
			ctrl_reg <= avs_writedata[1:0];
		end
	end

	// ********************************
	// per-queue status
	// ********************************
	genvar q;
	generate
		for (q = 0; q < NQ; q = q + 1) begin : g_queue
			wire sel_ofs = bus_wr && a_low_ok && a_base == `MQF_ADDR_OFS_BASE
				&& idx_of(avs_address) == q;
			wire sel_dep = bus_wr && a_low_ok && a_base == `MQF_ADDR_DEPTH_BASE
				&& idx_of(avs_address) == q;
			wire [OFS_W-1:0] ofs_cur = ofs_all[OFS_W*q +: OFS_W];
			wire [OFS_W-1:0] dep_cur = dep_all[OFS_W*q +: OFS_W];

			assign ofs_load[q] = init_load || sel_ofs;
			assign dep_load[q] = sel_dep;

			mqf_queue_flags #(
				.CNT_W (CNT_W),
				.OFS_W (OFS_W)
			) u_flags (
				.ref_clk   (ref_clk),
				.rst       (rst),
				.wr_evt    (write_en && wr_q_reg == q),
				.rd_evt    (read_en && rd_q_reg == q),
				.rd_here   (rd_q_reg == q),
				.in18      (in18),
				.out18     (out18),
				.ofs_load  (ofs_load[q]),
				.ofs_value (init_load ? ofs_default
					: lane_merge(ofs_cur, avs_writedata, avs_byteenable)),
				.dep_load  (dep_load[q]),
				.dep_value (lane_merge(dep_cur, avs_writedata, avs_byteenable)),
				.ofs_reg   (ofs_all[OFS_W*q +: OFS_W]),
				.dep_reg   (dep_all[OFS_W*q +: OFS_W]),
				.cnt_reg   (cnt_all[CNT_W*q +: CNT_W]),
				.ae_n_reg  (ae_stage[q]),
				.valid_now (valid_now[q]),
				.full_now  (full_now[q])
			);
		end
	endgenerate

	// ********************************
	// flag outputs
	// ********************************
	// second register stage; reads and writes reach it on the same edge, the
	// skew window is always met inside one clock so no extra cycle is ever added
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			active_almost_empty_flag_n   <= 1'b0;
			per_queue_almost_empty_bus_n <= {NQ{1'b0}};
			output_valid_flag_n          <= 1'b1;
			queue_full_flag_n            <= 1'b1;
		end else begin
			active_almost_empty_flag_n   <= ae_stage[rd_q_reg];
			per_queue_almost_empty_bus_n <= ae_stage;
			output_valid_flag_n          <= !valid_now[rd_q_next];
			queue_full_flag_n            <= !full_now[wr_q_next];
		end
	end

	// ********************************
	// register read mux
	// ********************************
	reg [31:0] rd_mux;

	always @* begin
		rd_mux = 32'h0000_0000;
		if (avs_address == `MQF_ADDR_CTRL) begin
			rd_mux[1:0] = ctrl_reg;
		end else if (avs_address == `MQF_ADDR_STATUS) begin
			rd_mux[`MQF_STAT_AE_LSB +: NQ]   = ae_stage;
			rd_mux[`MQF_STAT_FULL_LSB +: NQ] = full_now;
			rd_mux[`MQF_STAT_OV_LSB +: NQ]   = valid_now;
			rd_mux[`MQF_STAT_RDQ_LSB +: QW]  = rd_q_reg;
			rd_mux[`MQF_STAT_WRQ_LSB +: QW]  = wr_q_reg;
		end else if (a_low_ok && a_base == `MQF_ADDR_OFS_BASE) begin
			rd_mux[OFS_W-1:0] = ofs_all[OFS_W*idx_of(avs_address) +: OFS_W];
		end else if (a_low_ok && a_base == `MQF_ADDR_DEPTH_BASE) begin
			rd_mux[OFS_W-1:0] = dep_all[OFS_W*idx_of(avs_address) +: OFS_W];
		end else if (a_low_ok && a_base == `MQF_ADDR_COUNT_BASE) begin
			rd_mux[CNT_W-1:0] = cnt_all[CNT_W*idx_of(avs_address) +: CNT_W];
		end
	end

	// ********************************
	// avalon handshake
	// ********************************
	// one wait state per access; held off while defaults are still loading
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if ((avs_read || avs_write) && avs_waitrequest && !init_busy_reg) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

endmodule // mqf_multiqueue_flags

// File: testbench/mqf_flags_props.sv
`timescale 1ns/1ps
module mqf_flags_props #(
	parameter NQ = 4,
	parameter QW = 2
) (
	input wire          ref_clk,                      // clock
	input wire          rst,                          // reset
	input wire          write_en,                     // write
	input wire          write_select_strobe,          // write select
	input wire          read_en,                      // read
	input wire [QW-1:0] read_queue_select_bus,        // read queue
	input wire          read_select_strobe,           // read select
	input wire          avs_write,                    // bus write
	input wire          avs_waitrequest,              // bus stall
	input wire          active_almost_empty_flag_n,   // active flag
	input wire [NQ-1:0] per_queue_almost_empty_bus_n, // flag bus
	input wire          output_valid_flag_n,          // valid
	input wire          queue_full_flag_n             // full
);
	// ********
	// read queue in force
	// ********
	reg [QW-1:0] rq_h;
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			rq_h <= {QW{1'b0}};
		else if (read_select_strobe)
			rq_h <= read_queue_select_bus;
	end

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_reset_flags: assert property ($past(rst) |-> !active_almost_empty_flag_n
		&& per_queue_almost_empty_bus_n == 0 && output_valid_flag_n && queue_full_flag_n)
		else $error("flags wrong after reset");
	a_active_mirror: assert property (!read_select_strobe [*5] |->
		active_almost_empty_flag_n == per_queue_almost_empty_bus_n[rq_h])
		else $error("active flag differs from bus bit");
	a_ae_rise_write: assert property ($rose(active_almost_empty_flag_n) |->
		$past(write_en, 3) || $past(read_select_strobe, 3) || $past(read_select_strobe, 4))
		else $error("active flag rose without write");
	a_ae_fall_read: assert property ($fell(active_almost_empty_flag_n) |->
		$past(read_en, 3) || $past(read_select_strobe, 3) || $past(read_select_strobe, 4))
		else $error("active flag fell without read");
	a_bus_rise_write: assert property ((per_queue_almost_empty_bus_n
		& ~$past(per_queue_almost_empty_bus_n)) != 0 |-> $past(write_en, 3))
		else $error("bus bit rose without write");
	a_bus_fall_read: assert property ((~per_queue_almost_empty_bus_n
		& $past(per_queue_almost_empty_bus_n)) != 0 |-> $past(read_en, 3))
		else $error("bus bit fell without read");
	a_ov_fall_write: assert property ($fell(output_valid_flag_n) |->
		$past(write_en, 2) || $past(read_select_strobe, 2) || $past(read_select_strobe, 3))
		else $error("valid fell without write");
	a_ov_rise_read: assert property ($rose(output_valid_flag_n) |->
		$past(read_en) || $past(read_select_strobe, 2) || $past(read_select_strobe, 3))
		else $error("valid rose without read");
	a_full_fall_write: assert property ($fell(queue_full_flag_n) |->
		$past(write_en) || $past(write_select_strobe, 2) || $past(write_select_strobe, 3))
		else $error("full without write");
	a_full_rise_read: assert property ($rose(queue_full_flag_n) |->
		$past(read_en) || $past(write_select_strobe, 2) || $past(write_select_strobe, 3))
		else $error("full released without read");

	c_full_hit: cover property ($fell(queue_full_flag_n));
	c_ae_rise: cover property ($rose(active_almost_empty_flag_n));
	c_reg_write: cover property (avs_write && !avs_waitrequest);
endmodule // mqf_flags_props

bind mqf_multiqueue_flags mqf_flags_props #(.NQ(NQ), .QW(QW)) props_u (.*);

// File: testbench/mqf_ctl_model.sv
`timescale 1ns/1ps
module mqf_ctl_model #(
	parameter PER = 20
) (
	input  wire       ref_clk,               // clock
	output reg        write_en,              // write word
	output reg  [1:0] write_queue_select,    // write queue
	output reg        write_select_strobe,   // take write queue
	output reg        read_en,               // read word
	output reg  [1:0] read_queue_select_bus, // read queue
	output reg        read_select_strobe     // take read queue
);
	initial begin
		write_en = 1'b0;
		write_queue_select = 2'h0;
		write_select_strobe = 1'b0;
		read_en = 1'b0;
		read_queue_select_bus = 2'h0;
		read_select_strobe = 1'b0;
	end

	// numbers are only sampled with the strobe, so they are scrambled after it
	task sel(input logic [1:0] wq, input logic [1:0] rq);
		@(posedge ref_clk);
		write_queue_select <= wq;
		read_queue_select_bus <= rq;
		write_select_strobe <= 1'b1;
		read_select_strobe <= 1'b1;
		@(posedge ref_clk);
		write_select_strobe <= 1'b0;
		read_select_strobe <= 1'b0;
		write_queue_select <= ~wq;
		read_queue_select_bus <= ~rq;
		@(posedge ref_clk);
	endtask

	// e0 is the edge that samples the word
	task op(input bit rd, output int e0);
		@(posedge ref_clk);
		write_en <= !rd;
		read_en <= rd;
		e0 = int'($time / PER) + 2;
	endtask

	task idle(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			write_en <= 1'b0;
			read_en <= 1'b0;
		end
	endtask
endmodule // mqf_ctl_model

// File: testbench/mqf_multiqueue_flags_tb.sv
`timescale 1ns/1ps
module mqf_multiqueue_flags_tb;
	typedef struct packed {int c; logic [6:0] m; logic [6:0] v;} mqf_note_t;
	reg         ref_clk;
	reg         rst;
	reg         default_offset_select;
	reg  [7:0]  avs_address;
	reg         avs_read;
	reg         avs_write;
	reg  [31:0] avs_writedata;
	reg  [3:0]  avs_byteenable;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	wire        write_en;
	wire [1:0]  write_queue_select;
	wire        write_select_strobe;
	wire        read_en;
	wire [1:0]  read_queue_select_bus;
	wire        read_select_strobe;
	wire        active_almost_empty_flag_n;
	wire [3:0]  per_queue_almost_empty_bus_n;
	wire        output_valid_flag_n;
	wire        queue_full_flag_n;
	wire [6:0]  obs = {active_almost_empty_flag_n, per_queue_almost_empty_bus_n,
		output_valid_flag_n, queue_full_flag_n};
	int         cnt[4];
	int         ft[4];
	int         dep[4];
	int         ofs[4];
	int         wq;
	int         rq;
	int         wu;
	int         ru;
	int         n_fail;
	int         num_checks;
	logic [31:0] rs;
	logic [31:0] d;
	mqf_note_t  nq[$];

	mqf_multiqueue_flags dut_u (.*);
	mqf_ctl_model ctl_u (.*);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h exp %h", $time, s, e);
		end
	endtask

	// notes are kept sorted by cycle, as later words may expire earlier
	task note(input int c, input logic [6:0] m, input logic [6:0] v);
		int i;
		i = nq.size();
		while (i > 0 && nq[i-1].c > c)
			i--;
		nq.insert(i, mqf_note_t'{c, m, v & m});
	endtask

	always @(negedge ref_clk) begin
		while (nq.size() > 0 && nq[0].c <= int'($time / 20)) begin
			chk(obs & nq[0].m, nq[0].v);
			void'(nq.pop_front());
		end
	end

	task bus(input bit wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			n_fail++;
			give_verdict;
		end
	endtask

	task sel(input int w, input int r);
		ctl_u.idle(1);
		ctl_u.sel(w[1:0], r[1:0]);
		wq = w;
		rq = r;
	endtask

	// counts are in 9-bit units: a write adds wu, a read takes ru
	task step(input bit rd);
		int e;
		int q;
		int u;
		int lf;
		int la;
		logic [6:0] m;
		q = rd ? rq : wq;
		u = rd ? ru : wu;
		m = (7'h04 << q) | ((q == rq) ? 7'h40 : 7'h00);
		if (!rd && cnt[q] == 0)
			ft[q] = (q == rq && wu <= ru);
		lf = ((wu + ru > 2) ? 2 : 1) * (dep[q] + ft[q]);
		la = ((wu + ru > 2) ? 2 : 1) * (ofs[q] + 1 + ft[q]);
		ctl_u.op(rd, e);
		if (rd && cnt[q] >= u) begin
			if (cnt[q] >= lf && q == wq)
				note(e, 7'h01, 7'h7f);
			cnt[q] -= u;
			if (cnt[q] < la && cnt[q] + u >= la)
				note(e + 2, m, 7'h00);
			if (cnt[q] < u)
				note(e, 7'h02, 7'h7f);
		end else if (!rd && cnt[q] < lf) begin
			cnt[q] += u;
			if (q == rq && cnt[q] >= ru && cnt[q] < ru + u) begin
				note(e, 7'h02, 7'h7f);
				note(e + 1, 7'h02, 7'h00);
			end
			if (cnt[q] + u >= la && cnt[q] < la + u)
				note(e + 2, m, {7{cnt[q] >= la}});
			if (cnt[q] + u >= lf)
				note(e, 7'h01, {7{cnt[q] < lf}});
		end
		rs = xs(rs);
		ctl_u.idle(int'(rs[0]));
	endtask

	task done(input string s);
		ctl_u.idle(5);
		$display("test %s done", s);
	endtask

	initial begin
		rst = 1'b1;
		default_offset_select = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hf;
		rs = 32'h1006;
		wu = 1;
		ru = 1;
		dep = '{4{8192}};
		ofs = '{4{8}};
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		note(int'($time / 20) + 2, 7'h7f, 7'h03);
		bus(0, 8'h00, 0, d);
		chk(d, 32'h0000_0000);
		bus(0, 8'h10, 0, d);
		chk(d, 32'h0000_0008);
		bus(0, 8'h20, 0, d);
		chk(d, 32'h0000_2000);
		bus(0, 8'h44, 0, d);
		chk(d, 32'h0000_0000);
		dep[2] = 3 + rs[1:0];
		ofs[1] = 2 + rs[3:2];
		bus(1, 8'h28, dep[2], d);
		bus(1, 8'h14, ofs[1], d);
		bus(0, 8'h14, 0, d);
		chk(d, ofs[1]);
		done("registers");
		repeat (10) step(0);
		done("fill active queue");
		sel(1, 0);
		repeat (ofs[1] + 2) step(0);
		done("fill unselected queue");
		sel(2, 0);
		repeat (dep[2] + 1) step(0);
		done("fill to full");
		repeat (11) step(1);
		done("drain active queue");
		sel(2, 2);
		step(1);
		done("release full");
		chk(nq.size(), 0);
		// second reset with the strap high, then narrow in and wide out ports
		default_offset_select <= 1'b1;
		rst <= 1'b1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		cnt = '{4{0}};
		ft = '{4{0}};
		dep = '{4{8192}};
		ofs = '{4{128}};
		wq = 0;
		rq = 0;
		note(int'($time / 20) + 2, 7'h7f, 7'h03);
		bus(0, 8'h1c, 0, d);
		chk(d, 32'h0000_0080);
		bus(1, 8'h00, 32'h0000_0002, d);
		bus(0, 8'h00, 0, d);
		chk(d, 32'h0000_0002);
		ru = 2;
		rs = xs(rs);
		dep[0] = 5 + rs[3:2];
		ofs[0] = 1 + rs[1:0];
		bus(1, 8'h20, dep[0], d);
		bus(1, 8'h10, ofs[0], d);
		done("strap reset");
		repeat (2 * dep[0] + 3) step(0);
		done("narrow in wide out fill");
		repeat (dep[0] + 2) step(1);
		done("wide out drain");
		chk(nq.size(), 0);
		give_verdict;
	end
endmodule // mqf_multiqueue_flags_tb
